//--- include/pmrc_pkg.sv
/*
  constants for the power mode and reset control block: register
  offsets, bit positions, reset values and sequence counts.
  assumes a 10 MHz system clock and an avalon-mm register bus.
*/
// How it works
// - idle needs enable write then start write; both bits clear themselves.
// - enable and start in one write never enter idle or power-down.
// - idle stops cpu clock; peripherals run except watchdog in watchdog mode.
// - enabled interrupt or reset ends idle; cpu resumes after start write.
// - register contents and port states hold while idle.
// - idle gates video, acq, slicer, display, converters; wake-up stays on.
// - power-down needs enable write then start write; bits self-clear.
// - idle and power-down requested together: power-down wins.
// - only reset ends power-down; registers reinit, ram untouched.
// - each block power-save bit gates one block, also during idle.
// - reset leaving power-down restores all power-save bits.
// - power-save setting beats idle behaviour for a block.
// - slow-down bit divides system clock by four.
// - slow-down disables slicer, acq, display and masks their bus requests.
// - reset from pin or watchdog; watchdog reset leaves pll alone.
// - pin reset asserts asynchronously, registers clear on clock; release synchronous to clock.
// - after release a twelve-cycle initialisation sequence runs.
// - after reset cpu, acq and display hold no bus requests.
// - reset logic initialises no ram.
// - converter and wake-up raise no interrupts until sequence done.
// - after sequence the program counter starts at zero.
// - reset makes ports inputs except three port-4 address outputs.
package pmrc_pkg;
  // word addresses on the register bus (byte address = index * 4)
  localparam logic [3:0] pmrc_addr_power_mode_control = 4'h0;
  localparam logic [3:0] pmrc_addr_block_power_save = 4'h1;
  localparam logic [3:0] pmrc_addr_clock_power_save_ext = 4'h2;
  localparam logic [3:0] pmrc_addr_status = 4'h3;
  // power_mode_control bit positions
  localparam int pmrc_bit_idle_en = 0;
  localparam int pmrc_bit_pd_en = 1;
  localparam int pmrc_bit_gf0 = 2;
  localparam int pmrc_bit_gf1 = 3;
  localparam int pmrc_bit_slow = 4;
  localparam int pmrc_bit_idle_start = 5;
  localparam int pmrc_bit_pd_start = 6;
  localparam int pmrc_bit_smod = 7;
  // block_power_save bit positions (1 = block switched off)
  localparam int pmrc_ps_peri = 0;
  localparam int pmrc_ps_disp = 1;
  localparam int pmrc_ps_acq = 2;
  localparam int pmrc_ps_slicer = 3;
  localparam int pmrc_ps_vconv = 4;
  localparam int pmrc_ps_cconv = 5;
  localparam int pmrc_ps_wakeup = 6;
  localparam int pmrc_ps_oconv = 7;
  // clock_power_save_ext bits
  localparam int pmrc_px_pll_res = 3;
  // reset values
  localparam logic [7:0] pmrc_rst_power_mode_control = 8'h00;
  localparam logic [7:0] pmrc_rst_block_power_save = 8'h00;
  localparam logic [7:0] pmrc_rst_clock_power_save_ext = 8'h00;
  // port-4 pins that default to address outputs: 4.0, 4.1, 4.4
  localparam logic [7:0] pmrc_p4_addr_mask = 8'h13;
  // sequence counts
  localparam int pmrc_init_cycles = 12;
  localparam int pmrc_slow_div = 4;
  localparam logic [31:0] pmrc_unmapped = 32'h00000000;
  typedef enum logic [1:0] {pmrc_run, pmrc_idle, pmrc_pdown} pmrc_mode_type;
endpackage

//--- logic/pmrc_ctrl.sv
/*
  power mode and reset control: mode registers on avalon-mm, idle and
  power-down entry, block gating, clock slow-down and reset sequencing.
  assumes rst_pin_b and wdt_reset_req come from outside the clock domain
  (pin) or from logic on clk respectively; ram lives elsewhere.
*/
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/100ps
module pmrc_ctrl
  import pmrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rst_pin_b,
  input wire logic wdt_reset_req,
  input wire logic wdt_in_watchdog_mode,
  input wire logic irq_pending,
  input wire logic conv_irq_raw,
  input wire logic wakeup_irq_raw,
  input wire logic [2:0] bus_req_raw,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic wdt_clk_en,
  output logic [7:0] block_enable,
  output logic [2:0] bus_req_masked,
  output logic conv_irq,
  output logic wakeup_irq,
  output logic core_reset_b,
  output logic pll_reset,
  output logic init_done,
  output logic pc_reset_zero,
  output logic [7:0] p4_output_en,
  output logic [1:0] power_mode
);

  logic pin_s1, pin_s2;
  logic int_rst_b;
  logic [3:0] init_cnt;
  logic [7:0] power_mode_control;
  logic [7:0] block_power_save;
  logic [7:0] clock_power_save_ext;
  logic [1:0] div_cnt;
  logic ack;
  logic wr_power_mode_control;
  logic [7:0] wdat;
  logic idle_req, pd_req;
  logic [7:0] idle_gate;
  pmrc_mode_type mode;

  // pin passes two flops; pin low clears both asynchronously
  always_ff @(posedge clk or negedge rst_pin_b)
  begin
    if (!rst_pin_b)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= pin_s1;
    end
  end

  // internal reset: shared path of pin and watchdog, released on clk;
  // the pin drops it at once; the flops it resets still clear only on
  // the next clk edge, which a dead clock might not deliver
  always_ff @(posedge clk or negedge rst_pin_b)
  begin
    if (!rst_pin_b)
      int_rst_b <= 1'b0;
    else
      int_rst_b <= rst_b & pin_s2 & ~wdt_reset_req;
  end

  // pll reset follows only the pin path, never the watchdog
  assign pll_reset = ~pin_s2;

  // twelve-cycle initialisation sequence after release
  always_ff @(posedge clk)
  begin
    if (!int_rst_b)
      init_cnt <= 4'h0;
    else if (init_cnt != 4'(pmrc_init_cycles))
      init_cnt <= init_cnt + 4'h1;
  end

  assign init_done = (init_cnt == 4'(pmrc_init_cycles));
  assign core_reset_b = init_done;
  assign pc_reset_zero = ~init_done;
  // converter and wake-up interrupts held off during the sequence
  assign conv_irq = conv_irq_raw & init_done;
  assign wakeup_irq = wakeup_irq_raw & init_done;
  // ports are inputs during reset; three port-4 pins drive address
  assign p4_output_en = pmrc_p4_addr_mask;

  // avalon slave: single wait cycle so reads come from flops
  always_ff @(posedge clk)
  begin
    if (!int_rst_b)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_power_mode_control = avs_write & ack & (avs_address == pmrc_addr_power_mode_control)
                   & avs_byteenable[0];
  assign wdat = avs_writedata[7:0];
  // start bit alone, with the matching enable already latched
  assign idle_req = wr_power_mode_control & wdat[pmrc_bit_idle_start]
                    & ~wdat[pmrc_bit_idle_en] & power_mode_control[pmrc_bit_idle_en];
  assign pd_req = wr_power_mode_control & wdat[pmrc_bit_pd_start]
                  & ~wdat[pmrc_bit_pd_en] & power_mode_control[pmrc_bit_pd_en];

  // power_mode_control: enables armed only by a lone enable write
  always_ff @(posedge clk)
  begin
    if (!int_rst_b)
      power_mode_control <= pmrc_rst_power_mode_control;
    else if (wr_power_mode_control)
    begin
      power_mode_control[pmrc_bit_smod] <= wdat[pmrc_bit_smod];
      power_mode_control[pmrc_bit_slow] <= wdat[pmrc_bit_slow];
      power_mode_control[pmrc_bit_gf1] <= wdat[pmrc_bit_gf1];
      power_mode_control[pmrc_bit_gf0] <= wdat[pmrc_bit_gf0];
      // start bits never stored: they self-clear at once
      power_mode_control[pmrc_bit_idle_start] <= 1'b0;
      power_mode_control[pmrc_bit_pd_start] <= 1'b0;
      power_mode_control[pmrc_bit_idle_en] <= wdat[pmrc_bit_idle_en]
                                & ~wdat[pmrc_bit_idle_start];
      power_mode_control[pmrc_bit_pd_en] <= wdat[pmrc_bit_pd_en]
                              & ~wdat[pmrc_bit_pd_start];
    end
    else if (avs_write & ack)
    begin
      // any other write breaks the two-step sequence
      power_mode_control[pmrc_bit_idle_en] <= 1'b0;
      power_mode_control[pmrc_bit_pd_en] <= 1'b0;
    end
  end

  // power-save registers; only reset restores them
  always_ff @(posedge clk)
  begin
    if (!int_rst_b)
    begin
      block_power_save <= pmrc_rst_block_power_save;
      clock_power_save_ext <= pmrc_rst_clock_power_save_ext;
    end
    else if (avs_write & ack & avs_byteenable[0])
    begin
      if (avs_address == pmrc_addr_block_power_save)
        block_power_save <= wdat;
      if (avs_address == pmrc_addr_clock_power_save_ext)
        clock_power_save_ext <= wdat;
    end
  end

  // mode state: power-down wins, only reset leaves it
  always_ff @(posedge clk)
  begin
    if (!int_rst_b)
      mode <= pmrc_run;
    else
      case (mode)
        pmrc_run:
          if (pd_req)
            mode <= pmrc_pdown;
          else if (idle_req)
            mode <= pmrc_idle;
        pmrc_idle:
          if (pd_req)
            mode <= pmrc_pdown;
          else if (irq_pending)
            mode <= pmrc_run;
        pmrc_pdown:
          mode <= pmrc_pdown;
        default:
          mode <= pmrc_run;
      endcase
  end

  assign power_mode = mode;

  // divide-by-four enable when slowed down
  always_ff @(posedge clk)
  begin
    if (!int_rst_b)
      div_cnt <= 2'h0;
    else
      div_cnt <= div_cnt + 2'h1;
  end

  // slow-down gives one enable in four system clocks
  assign sys_clk_en = init_done & (mode != pmrc_pdown)
                      & (~power_mode_control[pmrc_bit_slow]
                         | (div_cnt == 2'(pmrc_slow_div - 1)));
  // cpu halted in idle; registers and ports frozen with it
  assign cpu_clk_en = sys_clk_en & (mode == pmrc_run);
  assign wdt_clk_en = sys_clk_en
                      & ~((mode == pmrc_idle) & wdt_in_watchdog_mode);

  // blocks switched off by idle; wake-up unit kept alive
  always_comb
  begin
    idle_gate = 8'h00;
    if (mode == pmrc_idle)
    begin
      idle_gate[pmrc_ps_vconv] = 1'b1;
      idle_gate[pmrc_ps_acq] = 1'b1;
      idle_gate[pmrc_ps_slicer] = 1'b1;
      idle_gate[pmrc_ps_disp] = 1'b1;
      idle_gate[pmrc_ps_cconv] = 1'b1;
      idle_gate[pmrc_ps_oconv] = 1'b1;
    end
  end

  // power-save bits always win; slow-down drops slicer, acq, display
  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_blk
      logic slow_off;
      assign slow_off = power_mode_control[pmrc_bit_slow]
                        & ((i == pmrc_ps_slicer) | (i == pmrc_ps_acq)
                           | (i == pmrc_ps_disp));
      assign block_enable[i] = init_done & (mode != pmrc_pdown)
                               & ~block_power_save[i] & ~idle_gate[i]
                               & ~slow_off;
    end
  endgenerate

  // bus requests: [0] cpu, [1] acq, [2] display; none during reset
  assign bus_req_masked[0] = bus_req_raw[0] & init_done;
  assign bus_req_masked[1] = bus_req_raw[1] & init_done
                             & block_enable[pmrc_ps_acq];
  assign bus_req_masked[2] = bus_req_raw[2] & init_done
                             & block_enable[pmrc_ps_disp];
  // no ram is held here, so reset clears none of it

  // read mux from flops; unmapped words read zero
  always_ff @(posedge clk)
  begin
    if (!int_rst_b)
      avs_readdata <= pmrc_unmapped;
    else if (avs_read & ~ack)
      case (avs_address)
        pmrc_addr_power_mode_control: avs_readdata <= {24'h000000, power_mode_control};
        pmrc_addr_block_power_save: avs_readdata <= {24'h000000, block_power_save};
        pmrc_addr_clock_power_save_ext: avs_readdata <= {24'h000000, clock_power_save_ext};
        pmrc_addr_status: avs_readdata <= {29'h00000000, init_done, mode};
        default: avs_readdata <= pmrc_unmapped;
      endcase
  end

  // checks

  // cycles since internal release, saturating; lets the sequence length
  // be checked by count instead of a long repetition the tools unroll
  logic [4:0] seq_cnt;

  always_ff @(posedge clk)
  begin
    if (!int_rst_b)
      seq_cnt <= 5'h00;
    else if (seq_cnt != 5'h1f)
      seq_cnt <= seq_cnt + 5'h01;
  end

  // no early release of the core
  property p_seq_len;
    @(posedge clk) disable iff (!int_rst_b)
      seq_cnt < 5'(pmrc_init_cycles) |-> !init_done;
  endproperty
  a_seq_len: assert property (p_seq_len)
    else $error("init sequence shorter than twelve cycles");

  // and no late one either
  property p_seq_done;
    @(posedge clk) disable iff (!int_rst_b)
      seq_cnt >= 5'(pmrc_init_cycles) |-> init_done;
  endproperty
  a_seq_done: assert property (p_seq_done)
    else $error("init sequence longer than twelve cycles");

  // no bus request leaks out while the sequence runs
  property p_bus_reset;
    @(posedge clk) !init_done |-> bus_req_masked == 3'h0;
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("bus request during reset sequence");

  property p_irq_hold;
    @(posedge clk) !init_done |-> !conv_irq && !wakeup_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("converter irq during reset sequence");

  property p_pd_sticky;
    @(posedge clk) disable iff (!int_rst_b)
      mode == pmrc_pdown |=> mode == pmrc_pdown;
  endproperty
  a_pd_sticky: assert property (p_pd_sticky)
    else $error("power-down left without reset");

  property p_same_write;
    @(posedge clk) disable iff (!int_rst_b)
      (mode == pmrc_run && wr_power_mode_control && wdat[pmrc_bit_idle_en]
       && wdat[pmrc_bit_idle_start] && !pd_req) |=> mode == pmrc_run;
  endproperty
  a_same_write: assert property (p_same_write)
    else $error("mode entered by one write");

  property p_pd_wins;
    @(posedge clk) disable iff (!int_rst_b)
      pd_req |=> mode == pmrc_pdown;
  endproperty
  a_pd_wins: assert property (p_pd_wins)
    else $error("power-down not taken");

  property p_cpu_idle;
    @(posedge clk) disable iff (!int_rst_b)
      mode == pmrc_idle |-> !cpu_clk_en && !block_enable[pmrc_ps_vconv];
  endproperty
  a_cpu_idle: assert property (p_cpu_idle)
    else $error("cpu or video clocked in idle");

  // an interrupt ends idle one edge later unless power-down is requested in that cycle
  property p_idle_exit;
    @(posedge clk) disable iff (!int_rst_b)
      mode == pmrc_idle && irq_pending && !pd_req |=> mode == pmrc_run;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("idle not left on interrupt");

  // wake-up unit keeps running in idle unless saved off
  property p_wakeup_idle;
    @(posedge clk) disable iff (!int_rst_b)
      mode == pmrc_idle && !block_power_save[pmrc_ps_wakeup]
      |-> block_enable[pmrc_ps_wakeup];
  endproperty
  a_wakeup_idle: assert property (p_wakeup_idle)
    else $error("wake-up unit stopped in idle");

  property p_block_power_save_wins;
    @(posedge clk) disable iff (!int_rst_b)
      block_power_save[pmrc_ps_wakeup] |-> !block_enable[pmrc_ps_wakeup];
  endproperty
  a_block_power_save_wins: assert property (p_block_power_save_wins)
    else $error("saved block enabled");

  property p_slow;
    @(posedge clk) disable iff (!int_rst_b)
      power_mode_control[pmrc_bit_slow] && sys_clk_en
      |=> (!sys_clk_en || !power_mode_control[pmrc_bit_slow]) [*3];
  endproperty
  a_slow: assert property (p_slow)
    else $error("slow-down not divide by four");

  property p_slow_bus;
    @(posedge clk) power_mode_control[pmrc_bit_slow] |-> bus_req_masked[2:1] == 2'b00;
  endproperty
  a_slow_bus: assert property (p_slow_bus)
    else $error("bus request in slow-down");

  c_idle: cover property (@(posedge clk) mode == pmrc_idle);
  c_pdown: cover property (@(posedge clk) mode == pmrc_pdown);
  c_wake: cover property (@(posedge clk)
    mode == pmrc_idle ##1 mode == pmrc_run);
  c_slow: cover property (@(posedge clk) power_mode_control[pmrc_bit_slow] && init_done);
  // watchdog reset seen with the pll left running
  c_wdt: cover property (@(posedge clk) wdt_reset_req && !pll_reset);

endmodule

//--- testbench/pmrc_ctrl_bench.sv
/*
  bench for pmrc_ctrl: integer model of modes and power-save bits,
  avalon master tasks, comparison at every result.
  assumes pmrc_pkg is compiled first; assertions sit in the design.
*/
`timescale 1ns/100ps
module pmrc_ctrl_bench;
  import pmrc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rst_pin_b = 1'b1;
  logic wdt_reset_req = 1'b0;
  logic wdt_in_watchdog_mode = 1'b1;
  logic irq_pending = 1'b0;
  logic conv_irq_raw = 1'b1;
  logic wakeup_irq_raw = 1'b1;
  logic [2:0] bus_req_raw = 3'h7;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, cpu_clk_en, sys_clk_en, wdt_clk_en;
  logic conv_irq, wakeup_irq, core_reset_b, pll_reset, init_done;
  logic pc_reset_zero;
  logic [7:0] block_enable, p4_output_en, power_mode_control_m, block_power_save_m, clock_power_save_ext_m;
  logic [2:0] bus_req_masked;
  logic [1:0] power_mode, en_m;
  int num_errors = 0;
  int checks_done = 0;
  int mode_m, n;

  pmrc_ctrl u_dut (.clk(clk), .rst_b(rst_b), .rst_pin_b(rst_pin_b),
    .wdt_reset_req(wdt_reset_req), .irq_pending(irq_pending),
    .wdt_in_watchdog_mode(wdt_in_watchdog_mode),
    .conv_irq_raw(conv_irq_raw), .wakeup_irq_raw(wakeup_irq_raw),
    .bus_req_raw(bus_req_raw), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .wdt_clk_en(wdt_clk_en), .block_enable(block_enable),
    .bus_req_masked(bus_req_masked), .conv_irq(conv_irq),
    .wakeup_irq(wakeup_irq), .core_reset_b(core_reset_b),
    .pll_reset(pll_reset), .init_done(init_done),
    .pc_reset_zero(pc_reset_zero), .p4_output_en(p4_output_en),
    .power_mode(power_mode));

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [7:0] d, output logic [31:0] rd);
    logic done;
    avs_address <= a;
    avs_writedata <= {24'($urandom), d};
    avs_byteenable <= {3'($urandom), 1'b1};
    avs_read <= !w;
    avs_write <= w;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clk);
      done = (avs_waitrequest === 1'b0);
      rd = avs_readdata;
      @(posedge clk);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // idle edge so a following request never re-drives in this step
    @(posedge clk);
  endtask

  // write plus model update
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic p;
    bus(1'b1, a, d, q);
    p = (a == pmrc_addr_power_mode_control);
    if (p && d[5] && !d[0] && en_m[0] && mode_m == 0) mode_m = 1;
    if (p && d[6] && !d[1] && en_m[1]) mode_m = 2;
    en_m = p ? d[1:0] & ~d[6:5] : 2'h0;
    if (p) power_mode_control_m = d & 8'h9c;
    if (a == pmrc_addr_block_power_save) block_power_save_m = d;
    if (a == pmrc_addr_clock_power_save_ext) clock_power_save_ext_m = d;
  endtask

  // idle keeps peri and wake-up; slow-down drops disp, acq, slicer
  function automatic logic [7:0] exp_blk();
    logic [7:0] e;
    e = ~block_power_save_m;
    if (mode_m == 1) e &= 8'h41;
    if (power_mode_control_m[4]) e &= 8'hf1;
    if (mode_m == 2) e = 8'h00;
    return e;
  endfunction

  task automatic check_all();
    logic [7:0] e;
    logic [2:0] eb;
    @(negedge clk);
    e = exp_blk();
    eb = {bus_req_raw[2] & e[pmrc_ps_disp], bus_req_raw[1] & e[pmrc_ps_acq],
      bus_req_raw[0]};
    chk("bus_req", eb, bus_req_masked);
    chk("conv_irq", conv_irq_raw, conv_irq);
    chk("wakeup_irq", wakeup_irq_raw, wakeup_irq);
    chk("core_rst", 1, core_reset_b);
    chk("pc_zero", 0, pc_reset_zero);
    chk("mode", 32'(mode_m), power_mode);
    chk("blocks", exp_blk(), block_enable);
    chk("p4_oe", 8'h13, p4_output_en);
    if (!power_mode_control_m[4])
    begin
      chk("cpu_clk", mode_m == 0, cpu_clk_en);
      chk("wdt_clk", !(mode_m == 1 && wdt_in_watchdog_mode), wdt_clk_en);
    end
    @(posedge clk);
    bus(1'b0, pmrc_addr_power_mode_control, 8'h0, q);
    chk("power_mode_control", power_mode_control_m, q & 32'hfc);
    bus(1'b0, pmrc_addr_block_power_save, 8'h0, q);
    chk("block_power_save", block_power_save_m, q);
    bus(1'b0, pmrc_addr_clock_power_save_ext, 8'h0, q);
    chk("clock_power_save_ext", clock_power_save_ext_m, q);
    bus(1'b0, pmrc_addr_status, 8'h0, q);
    chk("status", 32'h4 | 32'(mode_m), q);
  endtask

  // src 0 bench reset, 1 reset pin, 2 watchdog
  task automatic do_reset(input int src);
    mode_m = 0;
    en_m = 2'h0;
    power_mode_control_m = 8'h00;
    block_power_save_m = 8'h00;
    clock_power_save_ext_m = 8'h00;
    if (src == 0) rst_b <= 1'b0;
    if (src == 1) rst_pin_b <= 1'b0;
    if (src == 2) wdt_reset_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pll_reset", src == 1, pll_reset);
    rst_b <= 1'b1;
    rst_pin_b <= 1'b1;
    wdt_reset_req <= 1'b0;
    n = 0;
    @(negedge clk);
    while (init_done !== 1'b1 && n < 100)
    begin
      chk("conv_irq", 0, {wakeup_irq, conv_irq});
      chk("pc_zero", 1, pc_reset_zero);
      chk("bus_req", 0, bus_req_masked);
      n++;
      @(negedge clk);
    end
    // one edge for the registered reset, two more for the pin synchroniser
    chk("init_len", pmrc_init_cycles + ((src == 1) ? 3 : 1), n);
    @(posedge clk);
  endtask

  // main sequence
  initial
  begin
    void'($urandom(94));
    do_reset(0);
    check_all();
    bus(1'b0, 4'h7, 8'h0, q);
    chk("unmapped", 0, q);
    wr(4'h7, 8'hff);
    check_all();
    repeat (4)
    begin
      wr(pmrc_addr_block_power_save, 8'($urandom));
      wr(pmrc_addr_clock_power_save_ext, 8'($urandom) & 8'hf7);
      bus_req_raw <= 3'($urandom);
      conv_irq_raw <= 1'($urandom);
      wakeup_irq_raw <= 1'($urandom);
      check_all();
    end
    for (int i = 0; i < 2; i++)
    begin
      wdt_in_watchdog_mode <= i[0];
      wr(pmrc_addr_power_mode_control, 8'h01);
      wr(pmrc_addr_power_mode_control, 8'h20);
      check_all();
      irq_pending <= 1'b1;
      @(posedge clk);
      irq_pending <= 1'b0;
      mode_m = 0;
      repeat (2) @(posedge clk);
      check_all();
    end
    wr(pmrc_addr_power_mode_control, 8'h21);
    wr(pmrc_addr_power_mode_control, 8'h20);
    wr(pmrc_addr_power_mode_control, 8'h42);
    check_all();
    wr(pmrc_addr_block_power_save, 8'h00);
    wr(pmrc_addr_power_mode_control, 8'h10);
    bus_req_raw <= 3'h7;
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      n += sys_clk_en;
    end
    chk("slow_pulses", 2, n);
    chk("bus_mask", 3'h1, bus_req_masked);
    @(posedge clk);
    check_all();
    wr(pmrc_addr_power_mode_control, 8'h00);
    check_all();
    chk("sys_clk", 1, sys_clk_en);
    wr(pmrc_addr_block_power_save, 8'h5a);
    wr(pmrc_addr_power_mode_control, 8'h03);
    wr(pmrc_addr_power_mode_control, 8'h60);
    irq_pending <= 1'b1;
    repeat (3) @(posedge clk);
    irq_pending <= 1'b0;
    @(negedge clk);
    chk("mode", 2, power_mode);
    @(posedge clk);
    do_reset(1);
    check_all();
    do_reset(2);
    check_all();
    results();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #(100 * 20000);
    num_errors++;
    results();
  end
endmodule
